// >>> rtl/serial_rx_pkg.sv
package serial_rx_pkg;

  localparam int unsigned ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RX_CTRL  = 8'h18;
  localparam logic [7:0] IDX_TX_CTRL  = 8'h98;
  localparam logic [7:0] IDX_DIVISOR  = 8'h99;
  localparam logic [7:0] IDX_RX_BUF   = 8'h1A;
  localparam logic [7:0] IDX_RX_STATE = 8'h1B;

  // receive_status_control fields
  localparam int unsigned RC_PORT_EN = 7;
  localparam int unsigned RC_NINE    = 6;
  localparam int unsigned RC_SINGLE  = 5;
  localparam int unsigned RC_CONT    = 4;
  localparam int unsigned RC_ADDR    = 3;
  localparam int unsigned RC_FRAMING_ERROR_FLAG    = 2;
  localparam int unsigned RC_OVERRUN_ERROR_FLAG    = 1;
  localparam int unsigned RC_NINTH   = 0;

  // transmit_status_control fields
  localparam int unsigned TX_CLK_MASTER = 7;
  localparam int unsigned TX_SYNC       = 4;
  localparam int unsigned TX_HIGH_SPEED = 2;

  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [7:0] TX_WR_MASK  = 8'hF5;
  localparam logic [7:0] TX_RO_BITS  = 8'h02;

  // baud generator ticks per bit
  localparam logic [6:0] TICKS_ASYNC_LOW  = 7'h40;
  localparam logic [6:0] TICKS_ASYNC_HIGH = 7'h10;
  localparam logic [6:0] TICKS_SYNC       = 7'h04;

  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP, ST_SYNC} rx_state_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : byte_addr

  function automatic logic [6:0] ticks_per_bit(input logic sync, input logic high);
    if (sync) begin
      return TICKS_SYNC;
    end else if (high) begin
      return TICKS_ASYNC_HIGH;
    end else begin
      return TICKS_ASYNC_LOW;
    end
  endfunction : ticks_per_bit

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction : maj3

endpackage : serial_rx_pkg

// >>> rtl/serial_baud_timer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_baud_timer #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] divisor,
  input  wire logic         restart,
  output logic              tick
);

  logic [W-1:0] cnt_r;

  // RULE10 free-running down counter, one tick every divisor+1 clocks
  // restart clears, so the new divisor reloads at the very next tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (restart) begin
      cnt_r <= '0;
    end else if (cnt_r == '0) begin
      cnt_r <= divisor;
    end else begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign tick = (cnt_r == '0) && !restart;

  restart_load_a: // RULE16
    assert property (@(posedge clk) disable iff (rst) restart |=> (tick || restart))
    else $error("divisor write did not restart the timer");

  tick_period_a: // RULE10
    assert property (@(posedge clk) disable iff (rst)
      (tick && divisor == 8'h01 && $stable(divisor)) |=> !tick ##1 (tick || restart))
    else $error("baud tick period wrong");

endmodule : serial_baud_timer
`default_nettype wire

// >>> rtl/serial_rx_control.sv
// Notes on behaviour
// RULE1: port enable hands receive and clock pins to the serial port.
// RULE2: nine-bit select picks 9-bit or 8-bit reception.
// RULE3: single receive takes one word in sync master, then self-clears.
// RULE4: continuous receive runs nonstop; in sync it overrides single receive.
// RULE5: async 9-bit address detect keeps only words with ninth bit set.
// RULE6: with address detect off every word is kept; ninth bit free.
// RULE7: framing error is read-only and follows the buffered word.
// RULE8: overrun flag is read-only; clearing continuous receive clears it.
// RULE9: ninth received bit is shown read-only.
// RULE10: baud generator is a free-running 8-bit timer set by the divisor.
// RULE11: high-speed select matters only in async mode.
// RULE12: async rate is clock over 64 or 16 times divisor plus one.
// RULE13: sync rate is clock over 4 times divisor plus one.
// RULE14: rate formulas hold only when the device is clock master.
// RULE15: divisor accepts every value from 0 to 255.
// RULE16: writing the divisor restarts the baud timer at once.
// RULE17: software may prefer high-speed async for lower rate error.
// RULE18: receive pin is sampled three times per bit, majority decides; sync slave takes a single sample at each clock rise.
// RULE19: mode bit picks sync when set, async when clear.
// RULE20: high-speed bit picks high-speed async timing when set.
// RULE21: the three samples sit around mid-bit, paced by baud ticks.
// RULE22: a low stop bit sets the framing error flag.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module serial_rx_control (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RECEIVE_DATA_PIN,
  input  wire logic        TRANSMIT_CLOCK_PIN_IN,
  output logic             TRANSMIT_CLOCK_PIN_OUT,
  output logic             TRANSMIT_CLOCK_PIN_OE,
  output logic             SERIAL_PINS_OWNED
);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  logic [7:3] ctl_r;
  logic [7:0] tx_r;
  logic [7:0] div_r;
  logic [7:0] buf_data_r;
  logic       buf_ninth_r;
  logic       buf_framing_error_flag_r;
  logic       buf_full_r;
  logic       overrun_error_flag_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [1:0] pin_f_r;
  logic       ck_prev_r;
  logic       ck_out_r;
  logic [5:0] phase_r;
  logic [1:0] smp_r;
  logic [3:0] bitcnt_r;
  logic [8:0] sh_r;

  typedef serial_rx_pkg::rx_state_t rx_state_t;
  localparam rx_state_t ST_IDLE  = serial_rx_pkg::ST_IDLE;
  localparam rx_state_t ST_START = serial_rx_pkg::ST_START;
  localparam rx_state_t ST_DATA  = serial_rx_pkg::ST_DATA;
  localparam rx_state_t ST_STOP  = serial_rx_pkg::ST_STOP;
  localparam rx_state_t ST_SYNC  = serial_rx_pkg::ST_SYNC;
  rx_state_t  state_r;

  logic       access;
  logic       wr_rc;
  logic       wr_tx;
  logic       wr_div;
  logic       rd_buf;
  logic       mapped;
  logic [7:0] rd_mux;
  logic       port_en;
  logic       nine;
  logic       single_receive_enable;
  logic       continuous_receive_enable;
  logic       address_detect_enable;
  logic       sync;
  logic       master;
  logic       tick;
  logic [6:0] ticks;
  logic [6:0] mid;
  logic       at_last;
  logic       decide;
  logic       bit_now;
  logic       rx_f;
  logic       ck_rise;
  logic       async_on;
  logic       master_on;
  logic       slave_on;
  logic       bit_in;
  logic       shift_evt;
  logic       last_bit;
  logic [3:0] nbits;
  logic [8:0] word_w;
  logic       accept;
  logic       load_evt;
  logic       ovr_evt;
  logic       store_evt;
  logic       single_receive_enable_done;

  assign access = PSEL && PENABLE;
  assign PREADY = 1'b1;
  assign mapped = (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_CTRL))
               || (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_TX_CTRL))
               || (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_DIVISOR))
               || (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_BUF))
               || (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_STATE));
  assign PSLVERR = access && !mapped;
  assign wr_rc  = access && PWRITE
               && PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_CTRL);
  assign wr_tx  = access && PWRITE
               && PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_TX_CTRL);
  assign wr_div = access && PWRITE
               && PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_DIVISOR);
  assign rd_buf = access && !PWRITE
               && PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_BUF);

  assign port_en = ctl_r[serial_rx_pkg::RC_PORT_EN];
  assign nine    = ctl_r[serial_rx_pkg::RC_NINE];
  assign single_receive_enable    = ctl_r[serial_rx_pkg::RC_SINGLE];
  assign continuous_receive_enable    = ctl_r[serial_rx_pkg::RC_CONT];
  assign address_detect_enable   = ctl_r[serial_rx_pkg::RC_ADDR];
  // RULE19 mode select
  assign sync    = tx_r[serial_rx_pkg::TX_SYNC];
  assign master  = tx_r[serial_rx_pkg::TX_CLK_MASTER];

  // RULE1 pin handover
  assign SERIAL_PINS_OWNED      = port_en;
  assign TRANSMIT_CLOCK_PIN_OE  = port_en && sync && master;
  assign TRANSMIT_CLOCK_PIN_OUT = ck_out_r;

  always_comb begin
    if (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_CTRL)) begin
      // RULE9 status bits
      rd_mux = {ctl_r, buf_framing_error_flag_r, overrun_error_flag_r, buf_ninth_r};
    end else if (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_TX_CTRL)) begin
      rd_mux = (tx_r & serial_rx_pkg::TX_WR_MASK) | serial_rx_pkg::TX_RO_BITS;
    end else if (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_DIVISOR)) begin
      rd_mux = div_r;
    end else if (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_BUF)) begin
      rd_mux = buf_data_r;
    end else if (PADDR == serial_rx_pkg::byte_addr(serial_rx_pkg::IDX_RX_STATE)) begin
      rd_mux = {7'h00, buf_full_r};
    end else begin
      rd_mux = 8'h00;
    end
  end

  // read data captured in the setup cycle, held through the access cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {24'h000000, rd_mux};
    end
  end

  // RULE3 single receive self-clears
  assign single_receive_enable_done = last_bit && state_r == ST_SYNC && master && !continuous_receive_enable;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctl_r <= serial_rx_pkg::RX_CTRL_RST[7:3];
    end else if (wr_rc) begin
      ctl_r <= PWDATA[7:3];
    end else if (single_receive_enable_done) begin
      ctl_r[serial_rx_pkg::RC_SINGLE] <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tx_r <= serial_rx_pkg::TX_CTRL_RST & serial_rx_pkg::TX_WR_MASK;
    end else if (wr_tx) begin
      tx_r <= PWDATA[7:0] & serial_rx_pkg::TX_WR_MASK;
    end
  end

  // RULE15 full 8-bit divisor range
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      div_r <= serial_rx_pkg::DIVISOR_RST;
    end else if (wr_div) begin
      div_r <= PWDATA[7:0];
    end
  end

  // RULE16 restart on divisor write
  serial_baud_timer #(.W(8)) u_baud (
    .clk     (SYS_CLK),
    .rst     (RST),
    .divisor (div_r),
    .restart (wr_div),
    .tick    (tick)
  );

  // pins: change accepted once stages two and three agree
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_s3_r <= 2'h3;
      pin_f_r  <= 2'h3;
    end else begin
      pin_s1_r <= {TRANSMIT_CLOCK_PIN_IN, RECEIVE_DATA_PIN};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r  <= (~(pin_s2_r ^ pin_s3_r) & pin_s3_r) | ((pin_s2_r ^ pin_s3_r) & pin_f_r);
    end
  end

  assign rx_f    = pin_f_r[0];
  assign ck_rise = pin_f_r[1] && !ck_prev_r;

  // RULE11 RULE12 RULE13 RULE20 divide ratio per mode
  assign ticks   = serial_rx_pkg::ticks_per_bit(sync, tx_r[serial_rx_pkg::TX_HIGH_SPEED]);
  assign mid     = {1'b0, ticks[6:1]};
  assign at_last = {1'b0, phase_r} == ticks - 7'h01;
  assign decide  = tick && {1'b0, phase_r} == mid + 7'h01;
  // RULE18 majority of three samples
  assign bit_now = serial_rx_pkg::maj3({smp_r, rx_f});

  // RULE4 continuous receive in both modes
  assign async_on  = port_en && !overrun_error_flag_r && !sync && continuous_receive_enable;
  assign master_on = port_en && !overrun_error_flag_r && sync && master && (continuous_receive_enable || single_receive_enable);
  // RULE14 slave timing comes from the peer's clock, not the divisor
  assign slave_on  = port_en && !overrun_error_flag_r && sync && !master && continuous_receive_enable;

  // RULE2 word length
  assign nbits     = nine ? serial_rx_pkg::BITS_NINE : serial_rx_pkg::BITS_EIGHT;
  assign bit_in    = (state_r == ST_SYNC && !master) ? rx_f : bit_now;
  assign shift_evt = (state_r == ST_DATA && decide)
                  || (state_r == ST_SYNC && master && decide)
                  || (state_r == ST_SYNC && !master && ck_rise);
  assign last_bit  = shift_evt && bitcnt_r == nbits - 4'h1;
  assign word_w    = (state_r == ST_STOP) ? sh_r : {bit_in, sh_r[8:1]};

  // RULE5 RULE6 address filter only in async nine-bit mode
  assign accept    = state_r == ST_SYNC || !(nine && address_detect_enable) || word_w[8];
  assign load_evt  = ((state_r == ST_STOP && decide) || (state_r == ST_SYNC && last_bit))
                  && accept;
  // a read in the same cycle frees the slot, so that word is not an overrun
  assign ovr_evt   = load_evt && buf_full_r && !rd_buf;
  assign store_evt = load_evt && !ovr_evt;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (async_on && !rx_f) begin
            state_r <= ST_START;
          end else if (master_on || slave_on) begin
            state_r <= ST_SYNC;
          end
        end
        ST_START: begin
          if (!async_on) begin
            state_r <= ST_IDLE;
          end else if (decide) begin
            state_r <= bit_now ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (!async_on) begin
            state_r <= ST_IDLE;
          end else if (last_bit) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (!async_on || decide) begin
            state_r <= ST_IDLE;
          end
        end
        ST_SYNC: begin
          if (!(master_on || slave_on) || (last_bit && !continuous_receive_enable)) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // RULE21 phase counts baud ticks within one bit
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      phase_r <= 6'h00;
    end else if (state_r == ST_IDLE) begin
      phase_r <= 6'h00;
    end else if (tick) begin
      phase_r <= at_last ? 6'h00 : phase_r + 6'h01;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      smp_r <= 2'h3;
    end else if (tick && ({1'b0, phase_r} == mid - 7'h01 || {1'b0, phase_r} == mid)) begin
      smp_r <= {smp_r[0], rx_f};
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      bitcnt_r <= 4'h0;
      sh_r     <= 9'h000;
    end else if (state_r == ST_IDLE || last_bit) begin
      bitcnt_r <= 4'h0;
      sh_r     <= shift_evt ? word_w : sh_r;
    end else if (shift_evt) begin
      bitcnt_r <= bitcnt_r + 4'h1;
      sh_r     <= word_w;
    end
  end

  // master clock rises at mid-bit so the peer's data has settled
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ck_out_r  <= 1'b0;
      ck_prev_r <= 1'b1;
    end else begin
      ck_out_r  <= state_r == ST_SYNC && master && {1'b0, phase_r} >= mid;
      ck_prev_r <= pin_f_r[1];
    end
  end

  // RULE7 RULE22 status travels with the buffered word
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      buf_data_r  <= 8'h00;
      buf_ninth_r <= 1'b0;
      buf_framing_error_flag_r  <= 1'b0;
    end else if (store_evt) begin
      buf_data_r  <= nine ? word_w[7:0] : word_w[8:1];
      buf_ninth_r <= nine && word_w[8];
      buf_framing_error_flag_r  <= state_r == ST_STOP && !bit_now;
    end
  end

  // set wins over the read that frees the slot
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      buf_full_r <= 1'b0;
    end else if (store_evt) begin
      buf_full_r <= 1'b1;
    end else if (rd_buf) begin
      buf_full_r <= 1'b0;
    end
  end

  // RULE8 overrun held until continuous receive clears
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      overrun_error_flag_r <= 1'b0;
    end else begin
      overrun_error_flag_r <= ovr_evt || (overrun_error_flag_r && continuous_receive_enable);
    end
  end

  single_receive_enable_clear_a: // RULE3
    assert property (single_receive_enable_done && !wr_rc |=> !single_receive_enable)
    else $error("single receive not cleared after its word");

  overrun_error_flag_clear_a: // RULE8
    assert property (!continuous_receive_enable && !ovr_evt |=> !overrun_error_flag_r)
    else $error("overrun flag survived clear of continuous receive");

  framing_error_flag_stop_a: // RULE22
    assert property (state_r == ST_STOP && decide && !bit_now && store_evt |=> buf_framing_error_flag_r)
    else $error("low stop bit did not flag framing error");

  addr_filter_a: // RULE5
    assert property (state_r == ST_STOP && decide && nine && address_detect_enable && !sh_r[8] && !buf_full_r
                     |=> !buf_full_r)
    else $error("address detect kept a data word");

  port_off_a: // RULE1
    assert property (!port_en ##1 !port_en |-> state_r == ST_IDLE && !TRANSMIT_CLOCK_PIN_OE)
    else $error("receiver busy while port disabled");

  sync_ratio_a: // RULE11
    assert property (sync |-> ticks == 7'h04)
    else $error("sync bit time depends on high-speed select");

  cont_start_a: // RULE4
    assert property (state_r == ST_IDLE && sync && master && continuous_receive_enable && port_en && !overrun_error_flag_r
                     |=> state_r == ST_SYNC)
    else $error("continuous sync receive did not start");

  pin_filter_a: // RULE18
    assert property (rx_f != $past(rx_f) |-> $past(pin_s2_r[0]) == $past(pin_s3_r[0]))
    else $error("pin level accepted without agreement");

  overrun_a: // RULE8
    assert property (load_evt && buf_full_r && !rd_buf |=> overrun_error_flag_r && $stable(buf_data_r))
    else $error("overrun not flagged or buffer overwritten");

endmodule : serial_rx_control
`default_nettype wire

// >>> dv/serial_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        sync_mode,
  input  wire logic        nine,
  input  wire logic        bad_stop,
  input  wire logic [8:0]  word,
  input  wire logic [15:0] bit_cycles,
  input  wire logic        sclk,
  output logic             line,
  output logic             busy
);
  logic       async_bit;
  logic [3:0] idx;

  // after the last sync bit the line keeps changing, never holds stale data
  assign line = sync_mode ? ((idx < (nine ? 4'h9 : 4'h8)) ? word[idx] : idx[0]) : async_bit;

  always @(negedge sclk or posedge go) begin
    if (go) begin
      idx <= 4'h0;
    end else begin
      idx <= idx + 4'h1;
    end
  end

  initial begin : async_tx
    logic [10:0] fr;
    int          cnt;
    async_bit = 1'b1;
    busy      = 1'b0;
    forever begin
      @(posedge clk);
      if (go && !sync_mode) begin
        busy <= 1'b1;
        fr  = nine ? {~bad_stop, word, 1'b0} : {1'b1, ~bad_stop, word[7:0], 1'b0};
        cnt = nine ? 11 : 10;
        for (int i = 0; i < cnt; i++) begin
          async_bit <= fr[i];
          repeat (bit_cycles) @(posedge clk);
        end
        async_bit <= 1'b1;
        busy      <= 1'b0;
      end
    end
  end
endmodule : serial_peer_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [11:0] A_RC  = 12'h060;
  localparam logic [11:0] A_TX  = 12'h260;
  localparam logic [11:0] A_DIV = 12'h264;
  localparam logic [11:0] A_BUF = 12'h068;
  localparam logic [11:0] A_ST  = 12'h06C;

  logic        SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        rx_line, clk_out, clk_oe, owned;
  logic        slv_clk, peer_clk;
  logic        go, sync_mode, nine, bad_stop, busy, sclk_d;
  logic [8:0]  word;
  logic [15:0] bit_cycles;
  int          num_errors, total_checks, cyc, rises, last_rise, period;

  serial_rx_control dut_u (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RECEIVE_DATA_PIN(rx_line), .TRANSMIT_CLOCK_PIN_IN(slv_clk),
    .TRANSMIT_CLOCK_PIN_OUT(clk_out), .TRANSMIT_CLOCK_PIN_OE(clk_oe),
    .SERIAL_PINS_OWNED(owned));

  serial_peer_model peer_u (
    .clk(SYS_CLK), .go(go), .sync_mode(sync_mode), .nine(nine), .bad_stop(bad_stop),
    .word(word), .bit_cycles(bit_cycles), .sclk(peer_clk), .line(rx_line), .busy(busy));

  // peer follows the driven clock in master mode, the bench's clock in slave mode
  assign peer_clk = clk_oe ? clk_out : slv_clk;

  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  // measures the master clock period in system cycles
  always @(posedge SYS_CLK) begin
    cyc    <= cyc + 1;
    sclk_d <= clk_out;
    if (clk_out && !sclk_d) begin
      rises     <= rises + 1;
      last_rise <= cyc;
      period    <= cyc - last_rise;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    q       = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask : wreg

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, {24'h0, exp});
  endtask : rd

  task automatic send(input logic [8:0] w, input logic n9, input logic bs,
                      input logic [15:0] bc);
    int n;
    @(posedge SYS_CLK);
    word       <= w;
    nine       <= n9;
    bad_stop   <= bs;
    bit_cycles <= bc;
    go         <= 1'b1;
    @(posedge SYS_CLK);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (busy !== 1'b0 && n < 5000);
    repeat (4) @(posedge SYS_CLK);
  endtask : send

  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (50000) @(posedge SYS_CLK);
    num_errors++;
    final_report();
  end

  initial begin : main
    logic [31:0] q;
    logic        e;
    int          n, base;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {go, sync_mode, nine, bad_stop, word, slv_clk} = '0;
    {cyc, rises, last_rise, period, sclk_d, num_errors, total_checks} = '0;
    bit_cycles = 16'h0010;
    RST = 1'b1;
    repeat (5) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(A_RC, 8'h00);
    rd(A_TX, 8'h02);
    rd(A_DIV, 8'h00);
    apb(1'b0, 12'h100, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    wreg(A_TX, 8'hFF);
    rd(A_TX, 8'hF7);
    wreg(A_DIV, 8'hFF);
    rd(A_DIV, 8'hFF);
    // high speed for the finer divisor
    wreg(A_TX, 8'h04);
    wreg(A_DIV, 8'h00);
    wreg(A_RC, 8'h90);
    @(negedge SYS_CLK);
    check({31'h0, owned}, 32'h1);
    check({31'h0, clk_oe}, 32'h0);
    send(9'h0A5, 1'b0, 1'b0, 16'h0010);
    rd(A_ST, 8'h01);
    rd(A_BUF, 8'hA5);
    rd(A_ST, 8'h00);
    send(9'h05A, 1'b0, 1'b1, 16'h0010);
    rd(A_BUF, 8'h5A);
    rd(A_RC, 8'h94);
    send(9'h011, 1'b0, 1'b0, 16'h0010);
    rd(A_BUF, 8'h11);
    rd(A_RC, 8'h90);
    wreg(A_RC, 8'hD8);
    send(9'h033, 1'b1, 1'b0, 16'h0010);
    rd(A_ST, 8'h00);
    send(9'h144, 1'b1, 1'b0, 16'h0010);
    rd(A_RC, 8'hD9);
    rd(A_BUF, 8'h44);
    wreg(A_RC, 8'hD0);
    send(9'h066, 1'b1, 1'b0, 16'h0010);
    rd(A_RC, 8'hD0);
    rd(A_BUF, 8'h66);
    wreg(A_RC, 8'h90);
    send(9'h001, 1'b0, 1'b0, 16'h0010);
    send(9'h002, 1'b0, 1'b0, 16'h0010);
    rd(A_RC, 8'h92);
    rd(A_BUF, 8'h01);
    wreg(A_RC, 8'h80);
    rd(A_RC, 8'h80);
    wreg(A_TX, 8'h00);
    wreg(A_DIV, 8'h01);
    wreg(A_RC, 8'h90);
    send(9'h0C3, 1'b0, 1'b0, 16'h0080);
    rd(A_BUF, 8'hC3);
    wreg(A_RC, 8'h00);
    @(negedge SYS_CLK);
    check({31'h0, owned}, 32'h0);
    send(9'h0E7, 1'b0, 1'b0, 16'h0080);
    rd(A_ST, 8'h00);
    wreg(A_TX, 8'h94);
    wreg(A_DIV, 8'h02);
    sync_mode <= 1'b1;
    send(9'h03C, 1'b0, 1'b0, 16'h0004);
    base = rises;
    wreg(A_RC, 8'hA0);
    @(negedge SYS_CLK);
    check({31'h0, clk_oe}, 32'h1);
    n = 0;
    do begin
      apb(1'b0, A_ST, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b1 && n < 100);
    check(rises - base, 32'd8);
    check(period, 32'd12);
    rd(A_RC, 8'h80);
    rd(A_BUF, 8'h3C);
    // sync slave: bench drives the clock pin, single receive stays set
    wreg(A_TX, 8'h10);
    send(9'h0B4, 1'b0, 1'b0, 16'h0004);
    wreg(A_RC, 8'hB0);
    @(negedge SYS_CLK);
    check({31'h0, clk_oe}, 32'h0);
    repeat (8) begin
      repeat (6) @(posedge SYS_CLK);
      slv_clk <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      slv_clk <= 1'b0;
    end
    rd(A_BUF, 8'hB4);
    rd(A_RC, 8'hB0);
    final_report();
  end
endmodule : tb
`default_nettype wire
